// >>> design/atx_core.sv
// Function
// - Ninth transmit bit from C1_T9 when selected
// - Transmit LSB first through a buffer
// - Enabling transmitter drives pin, sends idle first
// - TX empty clears by status then data write
// - TX empty set as transfer begins; interrupt
// - Write during frame waits in buffer
// - Write while idle starts at once, empty again
// - Frame done flag after stop bit; interrupt
// - Break frames while set, then one mark
// - Transmit enable toggle queues idle, drops buffer
// - Receive LSB first, ninth bit kept
// - Receive enable starts start-bit hunt
// - Completed character loads buffer, sets full
// - Full flag clears by status then data read
// - Idle frame acts as character, own interrupt
// - Overrun keeps buffer, sets flag, interrupts
// - Samples 8-10 must agree, else noise
// - False start discarded, noise reported later
// - Missing stop or break sets framing error
// - Common prescaler 1, 3, 4 or 13
// - Independent power-of-two dividers up to 128
// - Start bit low, stop bit high
`timescale 1ns/100ps
module atx_core (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output wire logic        pready,
  output wire logic        pslverr,
  // Serial pins
  input  wire logic        serial_in_pin,
  output wire logic        serial_out_pin,
  output wire logic        serial_out_oe,
  // CPU
  input  wire logic        cpu_mask_flag,
  output wire logic        sci_irq
);
  // ****************************************
  // Baud generation
  // ****************************************
  logic [7:0] baud_q, baud_d, ctrl1_q, ctrl1_d, ctrl2_q, ctrl2_d;
  logic       pre_tick, tx_tick, rx_tick;

  atx_prescale u_pre (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .sel     (baud_q[atx_pkg::BR_PRE_LSB +: 2]),
    .tick    (pre_tick)
  );
  atx_pow2_div u_txdiv (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .in_tick (pre_tick),
    .sel     (baud_q[atx_pkg::BR_TX_LSB +: 3]),
    .tick    (tx_tick)
  );
  atx_pow2_div u_rxdiv (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .in_tick (pre_tick),
    .sel     (baud_q[atx_pkg::BR_RX_LSB +: 3]),
    .tick    (rx_tick)
  );

  // ****************************************
  // Bus decode
  // ****************************************
  logic acc, hit, data_wr, data_rd, clr_tx, clr_rx;
  logic armed_q, armed_d, txe_q, txe_d, done_q, done_d, rxf_q, rxf_d;
  logic idle_q, idle_d, or_q, or_d, nse_q, nse_d, ferr_q, ferr_d;
  logic [7:0] txbuf_q, txbuf_d, rxbuf_q, rxbuf_d;
  logic       bufv_q, bufv_d, r9_q, r9_d;
  logic [31:0] prdata_d;
  logic       word9, tx_on, rx_on, send_break;

  assign word9   = ctrl1_q[atx_pkg::C1_M];
  assign tx_on   = ctrl2_q[atx_pkg::C2_TXON];
  assign rx_on   = ctrl2_q[atx_pkg::C2_RXON];
  assign send_break     = ctrl2_q[atx_pkg::C2_BRK];
  assign acc     = psel && penable;
  assign hit     = (paddr == atx_pkg::OFS_STATUS) || (paddr == atx_pkg::OFS_DATA) ||
                   (paddr == atx_pkg::OFS_CTRL1) || (paddr == atx_pkg::OFS_CTRL2) ||
                   (paddr == atx_pkg::OFS_BAUD);
  assign pready  = 1'b1;
  assign pslverr = acc && !hit;
  assign data_wr = acc && pwrite && (paddr == atx_pkg::OFS_DATA);
  assign data_rd = acc && !pwrite && (paddr == atx_pkg::OFS_DATA);
  // Clearing needs a status access first; any data access disarms it
  assign clr_tx  = data_wr && armed_q;
  assign clr_rx  = data_rd && armed_q;

  // ****************************************
  // Transmitter
  // ****************************************
  atx_pkg::atx_tx_state_t tx_st_q, tx_st_d;
  atx_pkg::atx_kind_t     kind_q, kind_d;
  logic [10:0] tsh_q, tsh_d;
  logic [3:0]  tlen_q, tlen_d, tsub_q, tsub_d;
  logic        ipend_q, ipend_d, ton_q, tx_take, tx_fin, bit_end, pick;
  logic [3:0]  flen;

  assign flen    = word9 ? atx_pkg::LEN_9 : atx_pkg::LEN_8;
  assign bit_end = (tx_st_q == atx_pkg::TX_SEND) && tx_tick && (tsub_q == atx_pkg::SUB_LAST);

  always_comb begin
    tx_st_d = tx_st_q;
    kind_d  = kind_q;
    tsh_d   = tsh_q;
    tlen_d  = tlen_q;
    tsub_d  = tsub_q;
    ipend_d = ipend_q;
    tx_take = 1'b0;
    tx_fin  = 1'b0;
    pick    = 1'b0;
    if (tx_on && !ton_q) ipend_d = 1'b1;
    if (tx_tick) tsub_d = tsub_q + 4'h1;
    unique case (tx_st_q)
      atx_pkg::TX_OFF: begin
        if (tx_on) tx_st_d = atx_pkg::TX_READY;
      end
      atx_pkg::TX_READY: begin
        if (!tx_on) tx_st_d = atx_pkg::TX_OFF;
        else        pick    = 1'b1;
      end
      atx_pkg::TX_SEND: begin
        if (bit_end) begin
          tsh_d  = {1'b1, tsh_q[10:1]};
          tlen_d = tlen_q - 4'h1;
          if (tlen_q == 4'h1) begin
            tx_st_d = atx_pkg::TX_READY;
            tx_fin  = (kind_q == atx_pkg::FK_DATA);
            pick    = 1'b1;
          end
        end
      end
      default: tx_st_d = atx_pkg::TX_OFF;
    endcase
    // Next frame: break, closing mark, queued idle, then data
    if (pick && (tx_on || tx_st_q == atx_pkg::TX_SEND)) begin
      tsub_d = 4'h0;
      if (send_break) begin
        tx_st_d = atx_pkg::TX_SEND;
        kind_d  = atx_pkg::FK_BREAK;
        tsh_d   = 11'h000;
        tlen_d  = flen;
      end else if (tx_st_q == atx_pkg::TX_SEND && kind_q == atx_pkg::FK_BREAK) begin
        tx_st_d = atx_pkg::TX_SEND;
        kind_d  = atx_pkg::FK_MARK;
        tsh_d   = 11'h7ff;
        tlen_d  = atx_pkg::LEN_MARK;
      end else if (ipend_q && tx_on) begin
        tx_st_d = atx_pkg::TX_SEND;
        kind_d  = atx_pkg::FK_IDLE;
        tsh_d   = 11'h7ff;
        tlen_d  = flen;
        ipend_d = 1'b0;
      end else if (bufv_q && tx_on) begin
        tx_st_d = atx_pkg::TX_SEND;
        kind_d  = atx_pkg::FK_DATA;
        tx_take = 1'b1;
        // Stop in bit 10 for 9-bit frames; in 8-bit mode bit 9 is the stop and bit 10 is not sent
        tsh_d   = {1'b1, word9 ? ctrl1_q[atx_pkg::C1_T9] : 1'b1, txbuf_q, 1'b0};
        tlen_d  = flen;
      end else begin
        tx_st_d = tx_on ? atx_pkg::TX_READY : atx_pkg::TX_OFF;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      tx_st_q <= atx_pkg::TX_OFF;
      kind_q  <= atx_pkg::FK_DATA;
      tsh_q   <= 11'h7ff;
      tlen_q  <= 4'h0;
      tsub_q  <= 4'h0;
      ipend_q <= 1'b0;
      ton_q   <= 1'b0;
    end else begin
      tx_st_q <= tx_st_d;
      kind_q  <= kind_d;
      tsh_q   <= tsh_d;
      tlen_q  <= tlen_d;
      tsub_q  <= tsub_d;
      ipend_q <= ipend_d;
      ton_q   <= tx_on;
    end
  end

  // Line idles high whenever either direction is enabled
  assign serial_out_pin = (tx_st_q == atx_pkg::TX_SEND) ? tsh_q[0] : 1'b1;
  assign serial_out_oe  = tx_on || rx_on || (tx_st_q != atx_pkg::TX_OFF);

  // ****************************************
  // Receiver
  // ****************************************
  atx_pkg::atx_rx_state_t rx_st_q, rx_st_d;
  logic [3:0] rsub_q, rsub_d, rcnt_q, rcnt_d;
  logic [1:0] smp_q, smp_d;
  logic [2:0] hist_q, hist_d;
  logic [8:0] rsh_q, rsh_d;
  logic       fnoise_q, fnoise_d, npend_q, npend_d, iarm_q, iarm_d;
  logic [7:0] icnt_q, icnt_d;
  logic       maj, uni, rx_done, rx_ferr, rx_idle, rx_noise;
  logic [8:0] rx_word;

  assign maj = (smp_q[1] & smp_q[0]) | (smp_q[1] & serial_in_pin) | (smp_q[0] & serial_in_pin);
  assign uni = (smp_q[1] == smp_q[0]) && (smp_q[0] == serial_in_pin);

  always_comb begin
    rx_st_d  = rx_st_q;
    rsub_d   = rsub_q;
    rcnt_d   = rcnt_q;
    smp_d    = smp_q;
    hist_d   = hist_q;
    rsh_d    = rsh_q;
    fnoise_d = fnoise_q;
    npend_d  = npend_q;
    iarm_d   = iarm_q;
    icnt_d   = icnt_q;
    rx_done  = 1'b0;
    rx_ferr  = 1'b0;
    rx_idle  = 1'b0;
    rx_word  = word9 ? rsh_q : {1'b0, rsh_q[8:1]};
    rx_noise = fnoise_q || npend_q;
    if (!rx_on) begin
      rx_st_d = atx_pkg::RX_HUNT;
      hist_d  = 3'h0;
      iarm_d  = 1'b1;
      icnt_d  = 8'h00;
    end else if (rx_tick) begin
      rsub_d = rsub_q + 4'h1;
      unique case (rx_st_q)
        atx_pkg::RX_HUNT: begin
          hist_d = {hist_q[1:0], serial_in_pin};
          icnt_d = serial_in_pin ? icnt_q + 8'h01 : 8'h00;
          if (hist_q == 3'h7 && !serial_in_pin) begin
            rx_st_d  = atx_pkg::RX_BITS;
            rsub_d   = 4'h0;
            rcnt_d   = 4'h0;
            fnoise_d = 1'b0;
          end else if (iarm_q && icnt_q == {flen, 4'h0} - 8'h01) begin
            rx_idle  = 1'b1;
            rx_word  = 9'h1ff;
            rx_noise = npend_q;
            iarm_d   = 1'b0;
          end
        end
        atx_pkg::RX_BITS: begin
          if (rsub_q == atx_pkg::SMP_8TH || rsub_q == atx_pkg::SMP_9TH)
            smp_d = {smp_q[0], serial_in_pin};
          if (rsub_q == atx_pkg::SMP_10TH) begin
            if (!uni) fnoise_d = 1'b1;
            rcnt_d = rcnt_q + 4'h1;
            if (rcnt_q == 4'h0 && maj) begin
              rx_st_d = atx_pkg::RX_HUNT;
              npend_d = 1'b1;
              hist_d  = 3'h0;
            end else if (rcnt_q == flen - 4'h1) begin
              // Decide at the stop bit middle, so the hunt resyncs early
              rx_st_d = atx_pkg::RX_HUNT;
              rx_done = 1'b1;
              rx_ferr = !maj;
              rx_noise = fnoise_q || !uni || npend_q;
              npend_d = 1'b0;
              iarm_d  = 1'b1;
              icnt_d  = 8'h00;
              hist_d  = 3'h0;
            end else if (rcnt_q != 4'h0) begin
              rsh_d = {maj, rsh_q[8:1]};
            end
          end
        end
        default: rx_st_d = atx_pkg::RX_HUNT;
      endcase
    end
    if (rx_idle) npend_d = 1'b0;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rx_st_q  <= atx_pkg::RX_HUNT;
      rsub_q   <= 4'h0;
      rcnt_q   <= 4'h0;
      smp_q    <= 2'h0;
      hist_q   <= 3'h0;
      rsh_q    <= 9'h000;
      fnoise_q <= 1'b0;
      npend_q  <= 1'b0;
      iarm_q   <= 1'b1;
      icnt_q   <= 8'h00;
    end else begin
      rx_st_q  <= rx_st_d;
      rsub_q   <= rsub_d;
      rcnt_q   <= rcnt_d;
      smp_q    <= smp_d;
      hist_q   <= hist_d;
      rsh_q    <= rsh_d;
      fnoise_q <= fnoise_d;
      npend_q  <= npend_d;
      iarm_q   <= iarm_d;
      icnt_q   <= icnt_d;
    end
  end

  // ****************************************
  // Registers and flags
  // ****************************************
  always_comb begin
    armed_d = armed_q;
    ctrl1_d = ctrl1_q;
    ctrl2_d = ctrl2_q;
    baud_d  = baud_q;
    txbuf_d = txbuf_q;
    bufv_d  = bufv_q;
    rxbuf_d = rxbuf_q;
    r9_d    = r9_q;
    prdata_d = prdata;
    if (acc && paddr == atx_pkg::OFS_STATUS) armed_d = 1'b1;
    else if (data_wr || data_rd)            armed_d = 1'b0;
    if (acc && pwrite && paddr == atx_pkg::OFS_CTRL1) ctrl1_d = pwdata[7:0];
    if (acc && pwrite && paddr == atx_pkg::OFS_CTRL2) ctrl2_d = pwdata[7:0];
    if (acc && pwrite && paddr == atx_pkg::OFS_BAUD)  baud_d  = pwdata[7:0];
    if (tx_take) bufv_d = 1'b0;
    if (!tx_on && ton_q) bufv_d = 1'b0;
    if (data_wr) begin
      txbuf_d = pwdata[7:0];
      bufv_d  = 1'b1;
    end
    txe_d = clr_tx ? 1'b0 : txe_q;
    if (tx_take) txe_d = 1'b1;
    done_d = clr_tx ? 1'b0 : done_q;
    if (tx_fin) done_d = 1'b1;
    rxf_d  = clr_rx ? 1'b0 : rxf_q;
    idle_d = clr_rx ? 1'b0 : idle_q;
    or_d   = clr_rx ? 1'b0 : or_q;
    nse_d  = clr_rx ? 1'b0 : nse_q;
    ferr_d = clr_rx ? 1'b0 : ferr_q;
    // A character that lands in the clearing cycle loads: set wins
    if (rx_done || rx_idle) begin
      if (rxf_q && !clr_rx) begin
        or_d = 1'b1;
      end else begin
        rxbuf_d = rx_word[7:0];
        r9_d    = rx_word[8];
        rxf_d   = 1'b1;
        nse_d   = rx_noise;
        ferr_d  = rx_ferr;
        idle_d  = rx_idle;
      end
    end
    if (psel && !penable) begin
      unique case (paddr)
        atx_pkg::OFS_STATUS:
          prdata_d = {24'h0, txe_q, done_q, rxf_q, idle_q, or_q, nse_q, ferr_q, 1'b0};
        atx_pkg::OFS_DATA:  prdata_d = {24'h0, rxbuf_q};
        atx_pkg::OFS_CTRL1: prdata_d = {24'h0, r9_q, ctrl1_q[6:0]};
        atx_pkg::OFS_CTRL2: prdata_d = {24'h0, ctrl2_q};
        atx_pkg::OFS_BAUD:  prdata_d = {24'h0, baud_q};
        default:            prdata_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      armed_q <= 1'b0;
      ctrl1_q <= atx_pkg::CTRL_RST;
      ctrl2_q <= atx_pkg::CTRL_RST;
      baud_q  <= atx_pkg::BAUD_RST;
      txbuf_q <= 8'h00;
      bufv_q  <= 1'b0;
      rxbuf_q <= 8'h00;
      r9_q    <= 1'b0;
      txe_q   <= 1'b1;
      done_q  <= 1'b1;
      rxf_q   <= 1'b0;
      idle_q  <= 1'b0;
      or_q    <= 1'b0;
      nse_q   <= 1'b0;
      ferr_q  <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      armed_q <= armed_d;
      ctrl1_q <= ctrl1_d;
      ctrl2_q <= ctrl2_d;
      baud_q  <= baud_d;
      txbuf_q <= txbuf_d;
      bufv_q  <= bufv_d;
      rxbuf_q <= rxbuf_d;
      r9_q    <= r9_d;
      txe_q   <= txe_d;
      done_q  <= done_d;
      rxf_q   <= rxf_d;
      idle_q  <= idle_d;
      or_q    <= or_d;
      nse_q   <= nse_d;
      ferr_q  <= ferr_d;
      prdata  <= prdata_d;
    end
  end

  assign sci_irq = !cpu_mask_flag && (
                   (ctrl2_q[atx_pkg::C2_TXEIE] && txe_q) ||
                   (ctrl2_q[atx_pkg::C2_DONEIE] && done_q) ||
                   (ctrl2_q[atx_pkg::C2_RXIE] && (rxf_q || or_q)) ||
                   (ctrl2_q[atx_pkg::C2_IDLEIE] && idle_q));

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence s_false_start;
    rx_tick && rx_on && rx_st_q == atx_pkg::RX_BITS && rcnt_q == 4'h0 &&
      rsub_q == atx_pkg::SMP_10TH && maj && !clr_rx;
  endsequence

  chk_take_txe: assert property (tx_take |=> txe_q && tx_st_q == atx_pkg::TX_SEND)
    else $error("Empty flag not set when data starts");
  chk_start_low: assert property (tx_take |=> !serial_out_pin)
    else $error("Start bit not low");
  chk_break_low: assert property (tx_st_q == atx_pkg::TX_SEND &&
    kind_q == atx_pkg::FK_BREAK |-> !serial_out_pin)
    else $error("Break frame drives high");
  chk_txe_clear: assert property (clr_tx && !tx_take |=> !txe_q)
    else $error("Empty flag not cleared");
  chk_irq_mask: assert property (cpu_mask_flag |-> !sci_irq)
    else $error("Interrupt while masked");
  chk_rx_load: assert property (rx_done && !rxf_q |=>
    rxf_q && rxbuf_q == $past(rx_word[7:0]))
    else $error("Character not loaded");
  chk_overrun_keep: assert property (rx_done && rxf_q && !clr_rx |=>
    or_q && $stable(rxbuf_q))
    else $error("Overrun lost buffer or flag");
  chk_false_start: assert property (s_false_start |=>
    rx_st_q == atx_pkg::RX_HUNT && npend_q && $stable(rxf_q))
    else $error("False start not discarded");
  chk_frame_err: assert property (rx_done && rx_ferr && !rxf_q |=> ferr_q && rxf_q)
    else $error("Framing error not flagged");
endmodule

// >>> design/atx_pkg.sv
package atx_pkg;
  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_DATA   = 8'h04;
  localparam logic [7:0] OFS_CTRL1  = 8'h08;
  localparam logic [7:0] OFS_CTRL2  = 8'h0c;
  localparam logic [7:0] OFS_BAUD   = 8'h10;
  // Status bits
  localparam int ST_TXE  = 7;
  localparam int ST_DONE = 6;
  localparam int ST_RXF  = 5;
  localparam int ST_IDLE = 4;
  localparam int ST_OR   = 3;
  localparam int ST_NSE  = 2;
  localparam int ST_FERR = 1;
  // Control 1 bits
  localparam int C1_R9 = 7;
  localparam int C1_T9 = 6;
  localparam int C1_M  = 4;
  // Control 2 bits
  localparam int C2_TXEIE  = 7;
  localparam int C2_DONEIE = 6;
  localparam int C2_RXIE   = 5;
  localparam int C2_IDLEIE = 4;
  localparam int C2_TXON   = 3;
  localparam int C2_RXON   = 2;
  localparam int C2_BRK    = 0;
  // Baud fields
  localparam int BR_PRE_LSB = 6;
  localparam int BR_TX_LSB  = 3;
  localparam int BR_RX_LSB  = 0;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] BAUD_RST = 8'h00;
  // ****************************************
  // Timing
  // ****************************************
  localparam logic [3:0] PRE_0 = 4'h1;
  localparam logic [3:0] PRE_1 = 4'h3;
  localparam logic [3:0] PRE_2 = 4'h4;
  localparam logic [3:0] PRE_3 = 4'hd;
  localparam logic [3:0] SUB_LAST = 4'hf;
  localparam logic [3:0] SMP_8TH  = 4'h7;
  localparam logic [3:0] SMP_9TH  = 4'h8;
  localparam logic [3:0] SMP_10TH = 4'h9;
  localparam logic [3:0] LEN_8    = 4'ha;
  localparam logic [3:0] LEN_9    = 4'hb;
  localparam logic [3:0] LEN_MARK = 4'h1;
  typedef enum logic [1:0] {TX_OFF = 2'b00, TX_READY = 2'b01, TX_SEND = 2'b10} atx_tx_state_t;
  typedef enum logic [1:0] {FK_DATA = 2'b00, FK_IDLE = 2'b01, FK_BREAK = 2'b10,
                            FK_MARK = 2'b11} atx_kind_t;
  typedef enum logic {RX_HUNT = 1'b0, RX_BITS = 1'b1} atx_rx_state_t;
endpackage

// >>> design/atx_prescale.sv
`timescale 1ns/100ps
module atx_prescale (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  // Control
  input  wire logic [1:0] sel,
  // Output
  output wire logic       tick
);
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic [3:0] last;

  // ****************************************
  // Common prescaler 1, 3, 4 or 13
  // ****************************************
  always_comb begin
    unique case (sel)
      2'h0:    last = atx_pkg::PRE_0 - 4'h1;
      2'h1:    last = atx_pkg::PRE_1 - 4'h1;
      2'h2:    last = atx_pkg::PRE_2 - 4'h1;
      2'h3:    last = atx_pkg::PRE_3 - 4'h1;
    endcase
    cnt_d = (cnt_q >= last) ? 4'h0 : cnt_q + 4'h1;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) cnt_q <= 4'h0;
    else         cnt_q <= cnt_d;
  end

  assign tick = (cnt_q >= last);
endmodule

// >>> design/atx_pow2_div.sv
`timescale 1ns/100ps
module atx_pow2_div (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  // Control
  input  wire logic       in_tick,
  input  wire logic [2:0] sel,
  // Output
  output wire logic       tick
);
  logic [6:0] cnt_q;
  logic [6:0] cnt_d;
  logic [6:0] mask;

  // Power of two from 1 to 128; this tick runs at 16 times the bit rate
  always_comb begin
    mask  = 7'((8'h01 << sel) - 8'h01);
    cnt_d = in_tick ? cnt_q + 7'h01 : cnt_q;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) cnt_q <= 7'h00;
    else         cnt_q <= cnt_d;
  end

  assign tick = in_tick && ((cnt_q | ~mask) == 7'h7f);
endmodule

// >>> tb/atx_peer.sv
`timescale 1ns/100ps
module atx_peer (
  // Clock
  input  wire logic        clk_sys,
  // Serial lines
  input  wire logic        line_in,
  output logic             line_out,
  // Frame setup
  input  wire logic        nine,
  input  wire logic [11:0] bit_clk
);
  logic [8:0] rx_word;
  logic       rx_stop;
  int         rx_cnt = 0;
  initial line_out = 1'b1;
  // ****************************************
  // Receive: sample each bit at its middle
  // ****************************************
  always begin
    @(negedge line_in);
    repeat (bit_clk / 2) @(posedge clk_sys);
    rx_word = 9'h000;
    for (int i = 0; i < (nine ? 9 : 8); i++) begin
      repeat (bit_clk) @(posedge clk_sys);
      rx_word[i] = line_in;
    end
    repeat (bit_clk) @(posedge clk_sys);
    rx_stop = line_in;
    rx_cnt++;
  end
  // ****************************************
  // Send one frame
  // ****************************************
  // A glitch on data bit 0 probes the vote; a stop of 0 makes a framing error
  task automatic send(input logic [8:0] d, input logic stop, input logic glitch);
    logic [10:0] f;
    f = {1'b1, d, 1'b0};
    f[nine ? 10 : 9] = stop;
    for (int i = 0; i < (nine ? 11 : 10); i++) begin
      for (int k = 0; k < bit_clk; k++) begin
        @(posedge clk_sys);
        line_out <= (glitch && i == 1 && k == 8) ? ~f[i] : f[i];
      end
    end
    @(posedge clk_sys);
    line_out <= 1'b1;
  endtask
endmodule

// >>> tb/tb.sv
`timescale 1ns/100ps
module tb;
  // ****************************************
  // Signals
  // ****************************************
  logic        clk_sys = 1'b0;
  logic        sys_rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        ser_in;
  logic        ser_out;
  logic        ser_oe;
  logic        cpu_mask_flag = 1'b0;
  logic        sci_irq;
  logic        nine = 1'b0;
  logic [11:0] bit_clk = 12'h010;
  logic [31:0] rv;
  logic        er;
  int          num_errors = 0;
  int          checked = 0;
  localparam logic [31:0] EN = (32'h1 << atx_pkg::C2_TXON) | (32'h1 << atx_pkg::C2_RXON);
  localparam logic [7:0] ST = atx_pkg::OFS_STATUS;
  localparam logic [7:0] DT = atx_pkg::OFS_DATA;
  localparam logic [7:0] C2 = atx_pkg::OFS_CTRL2;
  always #20 clk_sys = ~clk_sys;
  atx_core atx_core_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serial_in_pin(ser_in), .serial_out_pin(ser_out),
    .serial_out_oe(ser_oe), .cpu_mask_flag(cpu_mask_flag), .sci_irq(sci_irq));
  atx_peer atx_peer_i (.clk_sys(clk_sys), .line_in(ser_out), .line_out(ser_in),
    .nine(nine), .bit_clk(bit_clk));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do @(posedge clk_sys); while (pready !== 1'b1);
    rv = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic poll(input int b);
    int t;
    t = 0;
    apb(1'b0, ST, 32'h0);
    while (rv[b] !== 1'b1 && t < 3000) begin
      apb(1'b0, ST, 32'h0);
      t++;
    end
    chk("poll", rv[b], 1);
  endtask
  task automatic wait_peer(input int n);
    int t;
    t = 0;
    while (atx_peer_i.rx_cnt < n && t < 20000) begin
      @(posedge clk_sys);
      t++;
    end
    chk("peer_frames", atx_peer_i.rx_cnt, n);
  endtask
  // Waits out the idle character that follows every frame, then clears it
  task automatic flush();
    repeat (400) @(posedge clk_sys);
    apb(1'b0, ST, 32'h0);
    chk("idle_flag", rv[atx_pkg::ST_IDLE], 1);
    apb(1'b0, DT, 32'h0);
  endtask
  task automatic tx_word(input logic [31:0] d, input logic [8:0] exp);
    int c;
    c = atx_peer_i.rx_cnt;
    apb(1'b0, ST, 32'h0);
    apb(1'b1, DT, d);
    wait_peer(c + 1);
    chk("tx_word", atx_peer_i.rx_word, exp);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    apb(1'b0, ST, 32'h0);
    chk("st_reset", rv, 32'hc0);
    apb(1'b0, atx_pkg::OFS_BAUD, 32'h0);
    chk("baud_reset", rv, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped", er, 1);
    chk("oe_reset", ser_oe, 0);
    $display("reset test done");
  endtask
  task automatic t_tx();
    int c;
    time t0;
    c = atx_peer_i.rx_cnt;
    t0 = $time;
    apb(1'b1, C2, EN);
    @(posedge clk_sys);
    chk("oe_on", ser_oe, 1);
    apb(1'b0, ST, 32'h0);
    apb(1'b1, DT, 32'ha5);
    poll(atx_pkg::ST_TXE);
    apb(1'b1, DT, 32'h5c);
    wait_peer(c + 1);
    chk("idle_first", ($time - t0) >= 12000, 1);
    chk("tx_w0", atx_peer_i.rx_word, 32'ha5);
    chk("tx_stop", atx_peer_i.rx_stop, 1);
    wait_peer(c + 2);
    chk("tx_w1", atx_peer_i.rx_word, 32'h5c);
    repeat (20) @(posedge clk_sys);
    apb(1'b0, ST, 32'h0);
    chk("done_flag", rv[atx_pkg::ST_DONE], 1);
    nine <= 1'b1;
    apb(1'b1, atx_pkg::OFS_CTRL1, (32'h1 << atx_pkg::C1_M) | (32'h1 << atx_pkg::C1_T9));
    apb(1'b0, ST, 32'h0);
    apb(1'b1, DT, 32'h3c);
    repeat (3) @(posedge clk_sys);
    apb(1'b0, ST, 32'h0);
    chk("txe_now", rv[atx_pkg::ST_TXE], 1);
    wait_peer(c + 3);
    chk("tx_nine", atx_peer_i.rx_word, 32'h13c);
    apb(1'b1, atx_pkg::OFS_CTRL1, 32'h0);
    nine <= 1'b0;
    $display("transmit test done");
  endtask
  task automatic t_brk();
    int c;
    c = atx_peer_i.rx_cnt;
    apb(1'b1, C2, EN | (32'h1 << atx_pkg::C2_BRK));
    wait_peer(c + 1);
    chk("brk_word", atx_peer_i.rx_word, 0);
    chk("brk_stop", atx_peer_i.rx_stop, 0);
    apb(1'b1, C2, EN);
    tx_word(32'h81, 9'h081);
    $display("break test done");
  endtask
  task automatic t_baud();
    logic [7:0]  bv [3] = '{8'h48, 8'hc0, 8'h90};
    logic [11:0] bc [3] = '{12'd96, 12'd208, 12'd256};
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, C2, 32'h0);
      apb(1'b1, atx_pkg::OFS_BAUD, {24'h0, bv[i]});
      bit_clk <= bc[i];
      apb(1'b1, C2, EN);
      tx_word(32'h96, 9'h096);
    end
    apb(1'b1, C2, 32'h0);
    apb(1'b1, atx_pkg::OFS_BAUD, 32'h0);
    bit_clk <= 12'h010;
    apb(1'b1, C2, EN | (32'h1 << atx_pkg::C2_RXIE));
    $display("baud test done");
  endtask
  task automatic t_rx();
    flush();
    atx_peer_i.send(9'h05a, 1'b1, 1'b0);
    poll(atx_pkg::ST_RXF);
    chk("irq_on", sci_irq, 1);
    cpu_mask_flag <= 1'b1;
    @(posedge clk_sys);
    chk("irq_mask", sci_irq, 0);
    cpu_mask_flag <= 1'b0;
    apb(1'b0, DT, 32'h0);
    chk("rx_data", rv, 32'h5a);
    apb(1'b0, ST, 32'h0);
    chk("rx_clear", rv[atx_pkg::ST_RXF], 0);
    flush();
    atx_peer_i.send(9'h011, 1'b1, 1'b0);
    atx_peer_i.send(9'h022, 1'b1, 1'b0);
    apb(1'b0, ST, 32'h0);
    chk("overrun", rv[atx_pkg::ST_OR], 1);
    apb(1'b0, DT, 32'h0);
    chk("ovr_keep", rv, 32'h11);
    flush();
    atx_peer_i.send(9'h033, 1'b0, 1'b0);
    apb(1'b0, ST, 32'h0);
    chk("framing", rv[atx_pkg::ST_FERR], 1);
    apb(1'b0, DT, 32'h0);
    chk("fe_data", rv, 32'h33);
    flush();
    atx_peer_i.send(9'h00f, 1'b1, 1'b1);
    apb(1'b0, ST, 32'h0);
    chk("noise", rv[atx_pkg::ST_NSE], 1);
    apb(1'b0, DT, 32'h0);
    chk("nf_data", rv, 32'h0f);
    $display("receive test done");
  endtask
  // ****************************************
  // Sequence and watchdog
  // ****************************************
  initial begin
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_reset();
    t_tx();
    t_brk();
    t_baud();
    t_rx();
    conclude();
  end
  initial begin
    repeat (100000) @(posedge clk_sys);
    num_errors++;
    conclude();
  end
endmodule
